// >>> inc/opm_defines.vh
`ifndef OPM_DEFINES_VH
`define OPM_DEFINES_VH

// register word indices, byte address is four times the index
`define OPM_IDX_BITBANG 14'h2022
`define OPM_IDX_RSEL_FIRST 14'h2009
`define OPM_IDX_RSEL_LAST 14'h200e
`define OPM_IDX_MAP_FIRST 14'h2405
`define OPM_IDX_MAP_LAST 14'h240b
`define OPM_IDX_PB_RSEL 14'h2450
`define OPM_IDX_TX_CTRL 14'h2456
`define OPM_IDX_RX_CTRL 14'h2457
`define OPM_IDX_EXT_GPIO 14'h2458
`define OPM_IDX_PORT_EN 14'h270c
`define OPM_IDX_PORT_MASK 14'h3fcf
`define OPM_IDX_PORT_MATCH 14'h0080

// field positions
`define OPM_BIT_BITBANG 0
`define OPM_BIT_TX_INV 0
`define OPM_BIT_TX_MOD 1
`define OPM_FLD_TX_SRC 3:2
`define OPM_BIT_RX_INV 1
`define OPM_BIT_RX_DIS 2
`define OPM_FLD_DUTY 5:4
`define OPM_BIT_PORT_EN 5
`define OPM_BIT_MAP_51 0
`define OPM_BIT_MAP_55 4
`define OPM_BIT_D51 0
`define OPM_BIT_D55 1
`define OPM_BIT_DIR51 4
`define OPM_BIT_DIR55 5

// write masks for implemented bits
`define OPM_MASK_BITBANG 8'h01
`define OPM_MASK_RSEL 8'h77
`define OPM_MASK_PB_RSEL 8'h07
`define OPM_MASK_TX_CTRL 8'h0f
`define OPM_MASK_RX_CTRL 8'h36
`define OPM_MASK_EXT_GPIO 8'h33
`define OPM_MASK_PORT_EN 8'h20

// reset values
`define OPM_RST_TX_CTRL 8'h08
`define OPM_RST_ZERO 8'h00
`define OPM_RST_PORT 8'hf0

// tx source codes
`define OPM_SRC_VAR 2'h0
`define OPM_SRC_WATT 2'h1
`define OPM_SRC_GPIO 2'h2
`define OPM_SRC_MOD 2'h3

// resource codes
`define OPM_RES_T0 3'h2
`define OPM_RES_T1 3'h3
`define OPM_RES_IRQ_HI 3'h4
`define OPM_RES_IRQ_LO 3'h5

// timing
`define OPM_CLK_HZ 100000000
`define OPM_CARRIER_HZ 38000

`endif

// >>> hw/opm_pin_mux.v
`timescale 1ns/10ps
`include "opm_defines.vh"

module opm_pin_mux #(
	parameter CLK_HZ = `OPM_CLK_HZ
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// avalon-mm slave
	input wire [15:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// internal sources, same clock
	input wire second_serial_tx,
	input wire var_pulse,
	input wire watt_pulse,
	input wire normal_powered_mode,
	input wire brownout_mode,
	input wire [15:0] lcd_seg_level,
	input wire lcd_level_51,
	input wire lcd_level_55,
	input wire ce_pulse_irq,
	// internal sinks
	output reg second_serial_rx,
	output reg timer0_count_clock,
	output reg timer1_count_clock,
	output reg high_priority_ext_irq,
	output reg low_priority_ext_irq,
	output reg pulse_irq,
	output reg pushbutton_level,
	// optical tx pin, also gp pin 51
	input wire optical_tx_pin_in,
	output reg optical_tx_pin_out,
	output reg optical_tx_pin_oe,
	// optical rx pin, also gp pin 55
	input wire optical_rx_pin_in,
	output reg optical_rx_pin_out,
	output reg optical_rx_pin_oe,
	// segment io pins 0 to 15
	input wire [15:0] seg_io_in,
	output reg [15:0] seg_io_out,
	output reg [15:0] seg_io_oe,
	// pushbutton
	input wire pushbutton_input
);

	// registers
	reg bitbang_q;
	reg [7:0] rsel_q [0:5];
	reg [7:0] map_q [0:6];
	reg [7:0] pb_rsel_q;
	reg [7:0] tx_ctrl_q;
	reg [7:0] rx_ctrl_q;
	reg [7:0] ext_gpio_q;
	reg [7:0] port_en_q;
	reg [7:0] port_q [0:3];
	reg ack_q;

	// synchronisers
	reg [15:0] seg_s1_q;
	reg [15:0] seg_s2_q;
	reg [2:0] pin_s1_q;
	reg [2:0] pin_s2_q;
	wire tx_pin_sync = pin_s2_q[0];
	wire rx_pin_sync = pin_s2_q[1];
	wire pb_sync = pin_s2_q[2];

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			seg_s1_q <= 16'h0000;
			seg_s2_q <= 16'h0000;
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end
		else
		begin
			seg_s1_q <= seg_io_in;
			seg_s2_q <= seg_s1_q;
			pin_s1_q <= {pushbutton_input, optical_rx_pin_in, optical_tx_pin_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	// bus decode
	wire [13:0] idx = avs_address[15:2];
	wire [13:0] rsel_off = idx - `OPM_IDX_RSEL_FIRST;
	wire [13:0] map_off = idx - `OPM_IDX_MAP_FIRST;
	wire [1:0] port_sel = idx[5:4];
	wire hit_rsel = (idx >= `OPM_IDX_RSEL_FIRST) && (idx <= `OPM_IDX_RSEL_LAST);
	wire hit_map = (idx >= `OPM_IDX_MAP_FIRST) && (idx <= `OPM_IDX_MAP_LAST);
	wire hit_port = (idx & `OPM_IDX_PORT_MASK) == `OPM_IDX_PORT_MATCH;
	wire req = avs_read | avs_write;
	wire wr_go = avs_write & ack_q & avs_byteenable[0];
	wire [7:0] wd = avs_writedata[7:0];

	// one wait state: every access completes on the second edge
	assign avs_waitrequest = req & ~ack_q;

	// decoded control fields
	wire tx_inv = tx_ctrl_q[`OPM_BIT_TX_INV];
	wire mod_en = tx_ctrl_q[`OPM_BIT_TX_MOD];
	wire [1:0] tx_src = tx_ctrl_q[`OPM_FLD_TX_SRC];
	wire rx_inv = rx_ctrl_q[`OPM_BIT_RX_INV];
	wire rx_dis = rx_ctrl_q[`OPM_BIT_RX_DIS];
	wire [1:0] duty = rx_ctrl_q[`OPM_FLD_DUTY];
	wire port_en = port_en_q[`OPM_BIT_PORT_EN];
	wire [15:0] seg_map = {map_q[5], map_q[6]};
	wire map51 = map_q[0][`OPM_BIT_MAP_51];
	wire map55 = map_q[0][`OPM_BIT_MAP_55];

	// per-pin data, direction and readback of the four port registers
	wire [15:0] seg_dat;
	wire [15:0] seg_dir;
	wire [15:0] seg_rd;
	wire [15:0] hit_t0;
	wire [15:0] hit_t1;
	wire [15:0] hit_hi;
	wire [15:0] hit_lo;
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1)
		begin : g_pin
			wire [2:0] rsel;
			wire [7:0] pq = port_q[g / 4];
			assign seg_dat[g] = pq[g % 4];
			assign seg_dir[g] = pq[4 + g % 4];
			assign seg_rd[g] = seg_dir[g] ? seg_dat[g] : seg_s2_q[g];
			if (g >= 2 && g <= 11)
			begin : g_res
				wire [7:0] rq = rsel_q[g / 2];
				assign rsel = rq[(g % 2) * 4 +: 3];
			end
			else
			begin : g_nores
				assign rsel = 3'h0;
			end
			// pin level, not the latch, so output pins still feed the resource
			assign hit_t0[g] = ~seg_map[g] & (rsel == `OPM_RES_T0) & seg_s2_q[g];
			assign hit_t1[g] = ~seg_map[g] & (rsel == `OPM_RES_T1) & seg_s2_q[g];
			assign hit_hi[g] = ~seg_map[g] & (rsel == `OPM_RES_IRQ_HI) & seg_s2_q[g];
			assign hit_lo[g] = ~seg_map[g] & (rsel == `OPM_RES_IRQ_LO) & seg_s2_q[g];
		end
	endgenerate

	wire [2:0] pb_rsel = pb_rsel_q[2:0];

	// register writes
	integer i;
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			ack_q <= 1'b0;
			bitbang_q <= 1'b0;
			pb_rsel_q <= `OPM_RST_ZERO;
			tx_ctrl_q <= `OPM_RST_TX_CTRL;
			rx_ctrl_q <= `OPM_RST_ZERO;
			ext_gpio_q <= `OPM_RST_ZERO;
			port_en_q <= `OPM_RST_ZERO;
			for (i = 0; i < 6; i = i + 1)
				rsel_q[i] <= `OPM_RST_ZERO;
			for (i = 0; i < 7; i = i + 1)
				map_q[i] <= `OPM_RST_ZERO;
			for (i = 0; i < 4; i = i + 1)
				port_q[i] <= `OPM_RST_PORT;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (wr_go)
			begin
				if (idx == `OPM_IDX_BITBANG)
					bitbang_q <= wd[`OPM_BIT_BITBANG];
				if (idx == `OPM_IDX_PB_RSEL)
					pb_rsel_q <= wd & `OPM_MASK_PB_RSEL;
				if (idx == `OPM_IDX_TX_CTRL)
					tx_ctrl_q <= wd & `OPM_MASK_TX_CTRL;
				if (idx == `OPM_IDX_RX_CTRL)
					rx_ctrl_q <= wd & `OPM_MASK_RX_CTRL;
				if (idx == `OPM_IDX_EXT_GPIO)
					ext_gpio_q <= wd & `OPM_MASK_EXT_GPIO;
				if (idx == `OPM_IDX_PORT_EN)
					port_en_q <= wd & `OPM_MASK_PORT_EN;
				if (hit_rsel)
					rsel_q[rsel_off[2:0]] <= wd & `OPM_MASK_RSEL;
				if (hit_map)
					map_q[map_off[2:0]] <= wd;
				if (hit_port)
					port_q[port_sel] <= wd;
			end
		end
	end

	// read mux, unmapped words read zero
	reg [7:0] rd;
	always @*
	begin
		rd = 8'h00;
		if (idx == `OPM_IDX_BITBANG)
			rd = {7'h00, bitbang_q};
		else if (idx == `OPM_IDX_PB_RSEL)
			rd = pb_rsel_q;
		else if (idx == `OPM_IDX_TX_CTRL)
			rd = tx_ctrl_q;
		else if (idx == `OPM_IDX_RX_CTRL)
			rd = rx_ctrl_q;
		else if (idx == `OPM_IDX_EXT_GPIO)
			rd = {2'h0, ext_gpio_q[5:4], 2'h0,
				ext_gpio_q[`OPM_BIT_DIR55] ? ext_gpio_q[`OPM_BIT_D55] : rx_pin_sync,
				ext_gpio_q[`OPM_BIT_DIR51] ? ext_gpio_q[`OPM_BIT_D51] : tx_pin_sync};
		else if (idx == `OPM_IDX_PORT_EN)
			rd = port_en_q;
		else if (hit_rsel)
			rd = rsel_q[rsel_off[2:0]];
		else if (hit_map)
			rd = map_q[map_off[2:0]];
		else if (hit_port)
		begin
			case (port_sel)
				2'h0: rd = {port_q[0][7:4], seg_rd[3:0]};
				2'h1: rd = {port_q[1][7:4], seg_rd[7:4]};
				2'h2: rd = {port_q[2][7:4], seg_rd[11:8]};
				2'h3: rd = {port_q[3][7:4], seg_rd[15:12]};
				default: rd = 8'h00;
			endcase
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
			avs_readdata <= 32'h00000000;
		else if (avs_read & ~ack_q)
			avs_readdata <= {24'h000000, rd};
	end

	// 38 kHz carrier, free running
	localparam integer CAR_CYC = CLK_HZ / `OPM_CARRIER_HZ;
	wire [31:0] car_cyc_w = CAR_CYC;
	wire [11:0] car_period = car_cyc_w[11:0];
	reg [11:0] car_cnt_q;
	reg [11:0] low_len;

	always @*
	begin
		case (duty)
			2'h0: low_len = {1'b0, car_period[11:1]};
			2'h1: low_len = {2'h0, car_period[11:2]};
			2'h2: low_len = {3'h0, car_period[11:3]};
			2'h3: low_len = {4'h0, car_period[11:4]};
			default: low_len = {1'b0, car_period[11:1]};
		endcase
	end

	always @(posedge clock)
	begin
		if (!rst_n)
			car_cnt_q <= 12'h000;
		else if (car_cnt_q >= car_period - 12'h001)
			car_cnt_q <= 12'h000;
		else
			car_cnt_q <= car_cnt_q + 12'h001;
	end

	wire car_low = car_cnt_q < low_len;
	// gp line five is pin 5 data latch, which stays in port 1 bit 1
	wire gp_line_five = seg_dat[5];
	wire mod_base = bitbang_q ? gp_line_five : second_serial_tx;
	// modulation outside normal and brownout falls back to the plain level
	wire mod_ok = mod_en & (normal_powered_mode | brownout_mode);
	wire mod_out = mod_ok ? (mod_base | ~car_low) : mod_base;

	// optical tx pin
	reg tx_out_d;
	reg tx_oe_d;
	always @*
	begin
		tx_out_d = 1'b0;
		tx_oe_d = 1'b1;
		case (tx_src)
			`OPM_SRC_VAR: tx_out_d = var_pulse;
			`OPM_SRC_WATT: tx_out_d = watt_pulse;
			`OPM_SRC_GPIO:
			begin
				if (map51)
					tx_out_d = lcd_level_51;
				else
				begin
					tx_out_d = ext_gpio_q[`OPM_BIT_D51];
					tx_oe_d = ext_gpio_q[`OPM_BIT_DIR51];
				end
			end
			`OPM_SRC_MOD: tx_out_d = mod_out;
			default: tx_out_d = 1'b0;
		endcase
		if (tx_src != `OPM_SRC_GPIO)
			tx_out_d = tx_out_d ^ tx_inv;
	end

	// optical rx pin
	reg rx_out_d;
	reg rx_oe_d;
	always @*
	begin
		rx_out_d = 1'b0;
		rx_oe_d = 1'b0;
		if (rx_dis)
		begin
			if (map55)
			begin
				rx_out_d = lcd_level_55;
				rx_oe_d = 1'b1;
			end
			else
			begin
				rx_out_d = ext_gpio_q[`OPM_BIT_D55];
				rx_oe_d = ext_gpio_q[`OPM_BIT_DIR55];
			end
		end
	end

	// segment pins
	reg [15:0] seg_out_d;
	reg [15:0] seg_oe_d;
	integer k;
	always @*
	begin
		for (k = 0; k < 16; k = k + 1)
		begin
			if (seg_map[k])
			begin
				seg_out_d[k] = lcd_seg_level[k];
				seg_oe_d[k] = 1'b1;
			end
			else
			begin
				seg_out_d[k] = seg_dat[k];
				seg_oe_d[k] = seg_dir[k] & port_en;
			end
		end
		if (bitbang_q)
		begin
			seg_out_d[5] = second_serial_tx;
			seg_oe_d[5] = 1'b1;
		end
	end

	// registered pin drive and internal routing
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			optical_tx_pin_out <= 1'b0;
			optical_tx_pin_oe <= 1'b0;
			optical_rx_pin_out <= 1'b0;
			optical_rx_pin_oe <= 1'b0;
			seg_io_out <= 16'h0000;
			seg_io_oe <= 16'h0000;
			second_serial_rx <= 1'b1;
			timer0_count_clock <= 1'b0;
			timer1_count_clock <= 1'b0;
			high_priority_ext_irq <= 1'b0;
			low_priority_ext_irq <= 1'b0;
			pulse_irq <= 1'b0;
			pushbutton_level <= 1'b0;
		end
		else
		begin
			optical_tx_pin_out <= tx_out_d;
			optical_tx_pin_oe <= tx_oe_d;
			optical_rx_pin_out <= rx_out_d;
			optical_rx_pin_oe <= rx_oe_d;
			seg_io_out <= seg_out_d;
			seg_io_oe <= seg_oe_d;
			// a disabled receiver idles high
			second_serial_rx <= rx_dis | (rx_pin_sync ^ rx_inv);
			timer0_count_clock <= (|hit_t0) | ((pb_rsel == `OPM_RES_T0) & pb_sync);
			timer1_count_clock <= (|hit_t1) | ((pb_rsel == `OPM_RES_T1) & pb_sync);
			high_priority_ext_irq <= (|hit_hi) | ((pb_rsel == `OPM_RES_IRQ_HI) & pb_sync);
			low_priority_ext_irq <= (|hit_lo) | ((pb_rsel == `OPM_RES_IRQ_LO) & pb_sync);
			pulse_irq <= ce_pulse_irq;
			pushbutton_level <= pb_sync;
		end
	end

endmodule // opm_pin_mux

// >>> bench/opm_asserts.sv
`timescale 1ns/10ps
module opm_asserts (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// register bus
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// internal lines and pins
	input wire ce_pulse_irq,
	input wire pulse_irq,
	input wire pushbutton_input,
	input wire pushbutton_level,
	input wire timer0_count_clock,
	input wire timer1_count_clock,
	input wire high_priority_ext_irq,
	input wire low_priority_ext_irq,
	input wire [15:0] seg_io_oe,
	input wire optical_tx_pin_oe,
	input wire optical_rx_pin_oe
);
	reg wrote_q;
	wire wr_done = avs_write & ~avs_waitrequest;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	always @(posedge clock)
		if (!rst_n)
			wrote_q <= 1'b0;
		else if (avs_write)
			wrote_q <= 1'b1;
	// must hold through reset itself
	property p_rst_quiet;
		disable iff (1'b0) !rst_n |=> seg_io_oe == 16'h0 && !optical_tx_pin_oe && !optical_rx_pin_oe;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("pin driven after reset");
	property p_pulse;
		1'b1 |=> pulse_irq == $past(ce_pulse_irq);
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse irq lag wrong");
	property p_pb;
		$stable(pushbutton_input) [*5] |-> pushbutton_level == pushbutton_input;
	endproperty
	a_pb: assert property (p_pb) else $error("pushbutton level wrong");
	property p_req_wait;
		$rose(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_req_wait: assert property (p_req_wait) else $error("request not held");
	property p_req_ack;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_req_ack: assert property (p_req_ack) else $error("access not answered");
	// no select written yet, so no resource may see a pin
	property p_res_idle;
		!wrote_q |-> !(timer0_count_clock || timer1_count_clock || high_priority_ext_irq || low_priority_ext_irq);
	endproperty
	a_res_idle: assert property (p_res_idle) else $error("resource active unselected");
	property p_oe_cause;
		seg_io_oe != $past(seg_io_oe) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
	property p_rdata_top;
		avs_readdata[31:8] == 24'h0;
	endproperty
	a_rdata_top: assert property (p_rdata_top) else $error("read data upper bits set");
endmodule // opm_asserts
bind opm_pin_mux opm_asserts opm_asserts_i (
	.clock(clock),
	.rst_n(rst_n),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.ce_pulse_irq(ce_pulse_irq),
	.pulse_irq(pulse_irq),
	.pushbutton_input(pushbutton_input),
	.pushbutton_level(pushbutton_level),
	.timer0_count_clock(timer0_count_clock),
	.timer1_count_clock(timer1_count_clock),
	.high_priority_ext_irq(high_priority_ext_irq),
	.low_priority_ext_irq(low_priority_ext_irq),
	.seg_io_oe(seg_io_oe),
	.optical_tx_pin_oe(optical_tx_pin_oe),
	.optical_rx_pin_oe(optical_rx_pin_oe)
);

// >>> bench/opm_pin_loads.sv
`timescale 1ns/10ps
module opm_pin_loads (
	// pins from the mux
	input wire tx_out,
	input wire tx_oe,
	input wire rx_out,
	input wire rx_oe,
	input wire [15:0] seg_out,
	input wire [15:0] seg_oe,
	// far side levels
	input wire light,
	input wire [15:0] load,
	// pin levels back
	output wire tx_in,
	output wire rx_in,
	output wire [15:0] seg_in
);
	// led pin has no keeper: undriven it shows the inverse, never a stale copy
	assign tx_in = tx_oe ? tx_out : ~tx_out;
	assign rx_in = rx_oe ? rx_out : light;
	assign seg_in = (seg_oe & seg_out) | (~seg_oe & load);
endmodule // opm_pin_loads

// >>> bench/test_optical_port_and_segment_io_mux.sv
`timescale 1ns/10ps
module test_optical_port_and_segment_io_mux;
	localparam integer P = 100000000 / 38000;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg [15:0] avs_address = 16'h0;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	reg sst = 1'b0, vp = 1'b0, wp = 1'b0, nm = 1'b0, bo = 1'b0, ce = 1'b0, pb = 1'b0, light = 1'b0;
	reg [15:0] load = 16'h0;
	wire t0, t1, ih, il, srx, txo, txe, txi, rxo, rxe, rxi, pi, pbl;
	wire [15:0] so, se, si;
	integer errors = 0;
	integer compares = 0;
	integer i, j, n;
	reg [7:0] q;
	always #5 clock = ~clock;
	opm_pin_mux opm_pin_mux_i (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_byteenable(4'hf), .second_serial_tx(sst), .var_pulse(vp),
		.watt_pulse(wp), .normal_powered_mode(nm), .brownout_mode(bo), .lcd_seg_level(16'haaaa),
		.lcd_level_51(1'b0), .lcd_level_55(1'b0), .ce_pulse_irq(ce), .second_serial_rx(srx),
		.timer0_count_clock(t0), .timer1_count_clock(t1), .high_priority_ext_irq(ih),
		.low_priority_ext_irq(il), .pulse_irq(pi), .pushbutton_level(pbl), .optical_tx_pin_in(txi),
		.optical_tx_pin_out(txo), .optical_tx_pin_oe(txe), .optical_rx_pin_in(rxi), .optical_rx_pin_out(rxo),
		.optical_rx_pin_oe(rxe), .seg_io_in(si), .seg_io_out(so), .seg_io_oe(se), .pushbutton_input(pb));
	opm_pin_loads opm_pin_loads_i (.tx_out(txo), .tx_oe(txe), .rx_out(rxo), .rx_oe(rxe), .seg_out(so),
		.seg_oe(se), .light(light), .load(load), .tx_in(txi), .rx_in(rxi), .seg_in(si));
	task ck(input [31:0] g, input [31:0] e);
	begin
		compares = compares + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task bus(input w, input [13:0] a, input [7:0] d);
	begin
		@(posedge clock);
		avs_address <= {a, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= ~w;
		n = 0;
		// waitrequest and read data are taken at the rising edge itself
		@(posedge clock);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			n = n + 1;
			@(posedge clock);
		end
		ck(n < 20, 1);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 20)
			summarize;
	end
	endtask
	task rd(input [13:0] a, input [7:0] e);
	begin
		bus(1'b0, a, 8'h0);
		ck(q, e);
	end
	endtask
	task st;
		repeat (4) @(negedge clock);
	endtask
	// one whole carrier period, so the phase does not matter
	task lows(input integer e);
	begin
		st;
		n = 0;
		repeat (P)
		begin
			@(negedge clock);
			n = n + (txo === 1'b0);
		end
		ck(n, e);
	end
	endtask
	task summarize;
	begin
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	initial
	begin
		#900000;
		errors = errors + 1;
		summarize;
	end
	initial
	begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		st;
		ck({se, txe, rxe}, 0);
		rd(14'h0080, 8'hf0);
		rd(14'h2456, 8'h08);
		rd(14'h240b, 8'h00);
		rd(14'h1000, 8'h00);
		bus(1, 14'h0080, 8'h35);
		load <= 16'h0004;
		st;
		ck(se, 0);
		bus(1, 14'h270c, 8'h20);
		st;
		ck({se[3:0], so[1:0]}, 6'h0d);
		rd(14'h0080, 8'h35);
		bus(1, 14'h240b, 8'h01);
		st;
		ck({se[0], so[0]}, 2'b10);
		for (i = 0; i < 6; i = i + 1)
		begin
			bus(1, 14'h200a, {1'b0, i[2:0], 1'b0, i[2:0]});
			for (j = 0; j < 4; j = j + 1)
			begin
				@(posedge clock);
				load <= {12'h0, j[1:0], 2'b00};
				st;
				ck({t0, t1, ih, il}, (i > 1 && j > 0) ? 4'h8 >> (i - 2) : 4'h0);
			end
		end
		bus(1, 14'h200a, 8'h00);
		bus(1, 14'h0090, 8'hf1);
		bus(1, 14'h200b, 8'h04);
		pb <= 1'b1;
		bus(1, 14'h2450, 8'h03);
		st;
		ck({ih, t1}, 2'b11);
		bus(1, 14'h2458, 8'h11);
		for (i = 0; i < 16; i = i + 1)
		begin
			@(posedge clock);
			{vp, wp, sst} <= i[3] ? 3'b001 : 3'b100;
			bus(1, 14'h2456, {4'h0, i[2:1], 1'b0, i[0]});
			st;
			ck({txo, txe}, {(i[2:1] == 2) ? 1'b1 : (i[2:1] == 0 ? vp : i[2:1] == 1 ? wp : sst) ^ i[0], 1'b1});
		end
		bus(1, 14'h2456, 8'h0e);
		sst <= 1'b0;
		for (i = 0; i < 6; i = i + 1)
		begin
			@(posedge clock);
			nm <= i < 4;
			bo <= i == 4;
			bus(1, 14'h2457, {2'b00, i[1:0], 4'h0});
			lows((i < 5) ? P >> (i[1:0] + 1) : P);
		end
		for (i = 0; i < 8; i = i + 1)
		begin
			@(posedge clock);
			light <= i[0];
			bus(1, 14'h2457, {5'h0, i[2:1], 1'b0});
			st;
			ck(srx, i[2] | (i[0] ^ i[1]));
		end
		bus(1, 14'h2458, 8'h22);
		st;
		ck({rxe, rxo}, 2'b11);
		bus(1, 14'h2456, 8'h0c);
		bus(1, 14'h0090, 8'hf2);
		bus(1, 14'h2022, 8'h01);
		st;
		ck({txo, so[5], se[5]}, 3'b101);
		@(posedge clock);
		sst <= 1'b1;
		st;
		ck(so[5], 1);
		rd(14'h2022, 8'h01);
		bus(1, 14'h2456, 8'h08);
		bus(1, 14'h2405, 8'h11);
		st;
		ck({txe, txo, rxe, rxo}, 4'b1010);
		ck(pbl, 1);
		ce <= 1'b1;
		@(posedge clock);
		ce <= 1'b0;
		@(negedge clock);
		ck(pi, 1);
		@(negedge clock);
		ck(pi, 0);
		repeat (3) @(posedge clock);
		summarize;
	end
endmodule // test_optical_port_and_segment_io_mux
